// ### verilog/bstap_map.svh
// offsets, codes, widths and reset values of the boundary-scan test port
//------------------------------------------------------------------------
// Summary of operation
// - four test inputs (clock, mode, data, optional reset) and one serial output
// - controller state changes only on a rising test clock edge or on test reset
// - mode select sampled at rising edge alone picks next of sixteen states
// - five rising edges with mode select high reach test-logic-reset
// - in test-logic-reset all test logic is inactive, buffer runs normally
// - controller enters its reset state at power-up unaided
// - test logic wins over the queue function for control of pins
// - run-test-idle acts only for instructions needing it, else idle
// - select-dr-scan branches to data path or select-ir-scan
// - select-ir-scan branches to instruction path or test-logic-reset
// - capture-ir loads fixed pattern whose two lowest bits are 01
// - shift-ir shifts captured pattern out and test data in each rise
// - exit1-ir branches to pause-ir or update-ir
// - pause-ir holds instruction shift stages unchanged
// - exit2-ir branches to shift-ir or update-ir
// - update-ir copies shifted instruction on falling edge; becomes current
// - capture-dr loads selected data register in parallel on rising edge
// - data path states mirror instruction path on selected data register
// - four-bit instruction: 0,1 boundary; 2 ident; 3 high-z bypass; f bypass
// - bypass stage loads zero in capture-dr
// - identification register: read-only 32 bits, version, part, maker
// - high-z instruction disables all outputs and selects bypass stage
//------------------------------------------------------------------------
`ifndef BSTAP_MAP_SVH
`define BSTAP_MAP_SVH

`define BSTAP_IR_W        4
`define BSTAP_IR_CAPTURE  4'h1
`define BSTAP_OP_EXTEST   4'h0
`define BSTAP_OP_SAMPLE   4'h1
`define BSTAP_OP_IDCODE   4'h2
`define BSTAP_OP_HIGHZ    4'h3
`define BSTAP_OP_BYPASS   4'hf
`define BSTAP_IR_RESET    4'h2
`define BSTAP_ID_W        32
`define BSTAP_N_IN        4
`define BSTAP_N_OUT       4
`define BSTAP_BSR_W       9
`define BSTAP_SYNC_W      8
`define BSTAP_TLR_ONES    3'h5

`endif

// ### verilog/bstap_pkg.sv
// types shared by the boundary-scan test port
package bstap_pkg;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } bstap_state_e;

  typedef enum logic [1:0] {
    SEL_BSR, SEL_IDC, SEL_BYP
  } bstap_dsel_e;

endpackage

// ### verilog/bstap_top.sv
// boundary-scan test access port: controller, instruction and data registers
`timescale 1ns/100ps
`default_nettype none
`include "bstap_map.svh"

module bstap_top #(
  parameter logic [3:0]  ID_VERSION = 4'h0,    // arbitrary value
  parameter logic [15:0] ID_PART    = 16'h5a3c, // arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h2a5   // arbitrary value
) (
  input  wire logic                    core_clk,  // system clock, 100 MHz
  input  wire logic                    rst,       // async reset, high
  input  wire logic                    clk_en,    // freezes all state when low
  input  wire logic                    tck,       // test clock pin
  input  wire logic                    tms,       // test mode select pin
  input  wire logic                    tdi,       // test data in pin
  input  wire logic                    trst_n,    // optional test reset pin
  output logic                         tdo,       // test data out
  output logic                         tdo_oe_n,  // tdo enable, low drives
  input  wire logic [`BSTAP_N_IN-1:0]  pin_in,    // input pads
  output logic      [`BSTAP_N_IN-1:0]  core_in,   // pad values to the queue
  input  wire logic [`BSTAP_N_OUT-1:0] func_out,  // queue output values
  input  wire logic                    func_oe_n, // queue output enable, low
  output logic      [`BSTAP_N_OUT-1:0] pin_out,   // output pad values
  output logic                         pin_oe_n   // output pad enable, low
);

  //----------------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------------
  logic [`BSTAP_SYNC_W-1:0] sync1_ff;
  logic [`BSTAP_SYNC_W-1:0] sync2_ff;
  logic                     tck_dly_ff;
  logic                     tck_s;
  logic                     tms_s;
  logic                     tdi_s;
  logic                     trst_n_s;
  logic [`BSTAP_N_IN-1:0]   pin_s;
  logic                     tck_rise;
  logic                     tck_fall;

  // tck sampled at 100 MHz; test clock must stay well below 50 MHz
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= {`BSTAP_SYNC_W{1'b0}};
      sync2_ff <= {`BSTAP_SYNC_W{1'b0}};
    end else if (clk_en) begin
      sync1_ff <= {trst_n, tdi, tms, tck, pin_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign {trst_n_s, tdi_s, tms_s, tck_s, pin_s} = sync2_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tck_dly_ff <= 1'b0;
    end else if (clk_en) begin
      tck_dly_ff <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_dly_ff;
  assign tck_fall = ~tck_s & tck_dly_ff;

  //----------------------------------------------------------------------
  // controller
  //----------------------------------------------------------------------
  bstap_pkg::bstap_state_e state_ff;
  bstap_pkg::bstap_state_e nxt_state;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      bstap_pkg::TLR:    nxt_state = tms_s ? bstap_pkg::TLR    : bstap_pkg::RTI;
      bstap_pkg::RTI:    nxt_state = tms_s ? bstap_pkg::SEL_DR : bstap_pkg::RTI;
      bstap_pkg::SEL_DR: nxt_state = tms_s ? bstap_pkg::SEL_IR : bstap_pkg::CAP_DR;
      bstap_pkg::CAP_DR: nxt_state = tms_s ? bstap_pkg::EX1_DR : bstap_pkg::SHF_DR;
      bstap_pkg::SHF_DR: nxt_state = tms_s ? bstap_pkg::EX1_DR : bstap_pkg::SHF_DR;
      bstap_pkg::EX1_DR: nxt_state = tms_s ? bstap_pkg::UPD_DR : bstap_pkg::PAU_DR;
      bstap_pkg::PAU_DR: nxt_state = tms_s ? bstap_pkg::EX2_DR : bstap_pkg::PAU_DR;
      bstap_pkg::EX2_DR: nxt_state = tms_s ? bstap_pkg::UPD_DR : bstap_pkg::SHF_DR;
      bstap_pkg::UPD_DR: nxt_state = tms_s ? bstap_pkg::SEL_DR : bstap_pkg::RTI;
      bstap_pkg::SEL_IR: nxt_state = tms_s ? bstap_pkg::TLR    : bstap_pkg::CAP_IR;
      bstap_pkg::CAP_IR: nxt_state = tms_s ? bstap_pkg::EX1_IR : bstap_pkg::SHF_IR;
      bstap_pkg::SHF_IR: nxt_state = tms_s ? bstap_pkg::EX1_IR : bstap_pkg::SHF_IR;
      bstap_pkg::EX1_IR: nxt_state = tms_s ? bstap_pkg::UPD_IR : bstap_pkg::PAU_IR;
      bstap_pkg::PAU_IR: nxt_state = tms_s ? bstap_pkg::EX2_IR : bstap_pkg::PAU_IR;
      bstap_pkg::EX2_IR: nxt_state = tms_s ? bstap_pkg::UPD_IR : bstap_pkg::SHF_IR;
      bstap_pkg::UPD_IR: nxt_state = tms_s ? bstap_pkg::SEL_DR : bstap_pkg::RTI;
    endcase
  end

  // the graph itself returns to reset after five tms-high edges; no counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= bstap_pkg::TLR;
    end else if (clk_en) begin
      if (!trst_n_s) begin
        state_ff <= bstap_pkg::TLR;
      end else if (tck_rise) begin
        state_ff <= nxt_state;
      end
    end
  end

  //----------------------------------------------------------------------
  // instruction register
  //----------------------------------------------------------------------
  logic [`BSTAP_IR_W-1:0] ir_sh_ff;
  logic [`BSTAP_IR_W-1:0] ir_cur_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ir_sh_ff <= `BSTAP_IR_CAPTURE;
    end else if (clk_en && tck_rise) begin
      if (state_ff == bstap_pkg::CAP_IR) begin
        ir_sh_ff <= `BSTAP_IR_CAPTURE;
      end else if (state_ff == bstap_pkg::SHF_IR) begin
        ir_sh_ff <= {tdi_s, ir_sh_ff[`BSTAP_IR_W-1:1]};
      end
    end
  end

  // pause and exit states leave ir_sh_ff alone
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ir_cur_ff <= `BSTAP_IR_RESET;
    end else if (clk_en) begin
      if (!trst_n_s || state_ff == bstap_pkg::TLR) begin
        ir_cur_ff <= `BSTAP_IR_RESET;
      end else if (tck_fall && state_ff == bstap_pkg::UPD_IR) begin
        ir_cur_ff <= ir_sh_ff;
      end
    end
  end

  //----------------------------------------------------------------------
  // instruction decode
  //----------------------------------------------------------------------
  function automatic bstap_pkg::bstap_dsel_e dr_select(input logic [`BSTAP_IR_W-1:0] op);
    unique case (op)
      `BSTAP_OP_EXTEST,
      `BSTAP_OP_SAMPLE: dr_select = bstap_pkg::SEL_BSR;
      `BSTAP_OP_IDCODE: dr_select = bstap_pkg::SEL_IDC;
      default:          dr_select = bstap_pkg::SEL_BYP; // unknown codes act as bypass
    endcase
  endfunction

  bstap_pkg::bstap_dsel_e dsel;
  logic                   op_extest;
  logic                   op_highz;

  assign dsel      = dr_select(ir_cur_ff);
  assign op_extest = (ir_cur_ff == `BSTAP_OP_EXTEST);
  assign op_highz  = (ir_cur_ff == `BSTAP_OP_HIGHZ);

  //----------------------------------------------------------------------
  // data registers
  //----------------------------------------------------------------------
  logic                    byp_ff;
  logic [`BSTAP_ID_W-1:0]  id_sh_ff;
  logic [`BSTAP_BSR_W-1:0] bsr_sh_ff;
  logic [`BSTAP_BSR_W-1:0] bsr_upd_ff;
  logic                    dr_cap;
  logic                    dr_shf;

  // no instruction here has a run-test-idle action, so idle does nothing
  assign dr_cap = clk_en & tck_rise & (state_ff == bstap_pkg::CAP_DR);
  assign dr_shf = clk_en & tck_rise & (state_ff == bstap_pkg::SHF_DR);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      byp_ff <= 1'b0;
    end else if (dsel == bstap_pkg::SEL_BYP) begin
      if (dr_cap) begin
        byp_ff <= 1'b0;
      end else if (dr_shf) begin
        byp_ff <= tdi_s;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      id_sh_ff <= {`BSTAP_ID_W{1'b0}};
    end else if (dsel == bstap_pkg::SEL_IDC) begin
      if (dr_cap) begin
        id_sh_ff <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
      end else if (dr_shf) begin
        id_sh_ff <= {tdi_s, id_sh_ff[`BSTAP_ID_W-1:1]};
      end
    end
  end

  // cell order: inputs low, outputs next, output enable at the top
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bsr_sh_ff <= {`BSTAP_BSR_W{1'b0}};
    end else if (dsel == bstap_pkg::SEL_BSR) begin
      if (dr_cap) begin
        bsr_sh_ff <= {func_oe_n, func_out, pin_s};
      end else if (dr_shf) begin
        bsr_sh_ff <= {tdi_s, bsr_sh_ff[`BSTAP_BSR_W-1:1]};
      end
    end
  end

  // update stage only moves on the falling edge, so pads never see shifting
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bsr_upd_ff <= {1'b1, {(`BSTAP_BSR_W-1){1'b0}}};
    end else if (clk_en && tck_fall && state_ff == bstap_pkg::UPD_DR
                 && dsel == bstap_pkg::SEL_BSR) begin
      bsr_upd_ff <= bsr_sh_ff;
    end
  end

  //----------------------------------------------------------------------
  // serial output
  //----------------------------------------------------------------------
  logic shift_st;
  logic nxt_tdo;

  assign shift_st = (state_ff == bstap_pkg::SHF_IR) || (state_ff == bstap_pkg::SHF_DR);

  always_comb begin
    nxt_tdo = byp_ff;
    if (state_ff == bstap_pkg::SHF_IR) begin
      nxt_tdo = ir_sh_ff[0];
    end else begin
      unique case (dsel)
        bstap_pkg::SEL_BSR: nxt_tdo = bsr_sh_ff[0];
        bstap_pkg::SEL_IDC: nxt_tdo = id_sh_ff[0];
        bstap_pkg::SEL_BYP: nxt_tdo = byp_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (clk_en && tck_fall) begin
      tdo      <= nxt_tdo;
      tdo_oe_n <= ~shift_st;
    end
  end

  //----------------------------------------------------------------------
  // pad muxing
  //----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_out  <= {`BSTAP_N_OUT{1'b0}};
      pin_oe_n <= 1'b1;
      core_in  <= {`BSTAP_N_IN{1'b0}};
    end else if (clk_en) begin
      core_in <= pin_s;
      if (op_highz) begin
        pin_out  <= func_out;
        pin_oe_n <= 1'b1;
      end else if (op_extest) begin
        pin_out  <= bsr_upd_ff[`BSTAP_BSR_W-2:`BSTAP_N_IN];
        pin_oe_n <= bsr_upd_ff[`BSTAP_BSR_W-1];
      end else begin
        pin_out  <= func_out;
        pin_oe_n <= func_oe_n;
      end
    end
  end

endmodule
`default_nettype wire

// ### tb/bstap_chk.sv
// port assertions for the boundary-scan test port
`timescale 1ns/100ps
`default_nettype none
`include "bstap_map.svh"
module bstap_chk (
  input wire logic                    core_clk,  // system clock
  input wire logic                    rst,       // async reset
  input wire logic                    clk_en,    // clock enable
  input wire logic                    tck,       // test clock pin
  input wire logic                    tms,       // mode select pin
  input wire logic                    tdi,       // test data in
  input wire logic                    trst_n,    // test reset
  input wire logic                    tdo,       // test data out
  input wire logic                    tdo_oe_n,  // tdo enable
  input wire logic [`BSTAP_N_IN-1:0]  pin_in,    // input pads
  input wire logic [`BSTAP_N_IN-1:0]  core_in,   // pads to queue
  input wire logic [`BSTAP_N_OUT-1:0] func_out,  // queue outputs
  input wire logic                    func_oe_n, // queue enable
  input wire logic [`BSTAP_N_OUT-1:0] pin_out,   // output pads
  input wire logic                    pin_oe_n   // output pad enable
);
  // ----------------------------------------
  // tck edges seen through the same sync depth as the block
  // ----------------------------------------
  logic       tck1_ff, tck2_ff, tck3_ff, tms1_ff, tms2_ff, last_tms_ff;
  logic [2:0] ones_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {tck1_ff, tck2_ff, tck3_ff, tms1_ff, tms2_ff} <= '0;
    end else if (clk_en) begin
      {tck1_ff, tck2_ff, tck3_ff} <= {tck, tck1_ff, tck2_ff};
      {tms1_ff, tms2_ff} <= {tms, tms1_ff};
    end
  end
  // run of tms-high rises, saturating where the controller must sit in reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ones_ff <= 3'h0;
      last_tms_ff <= 1'b1;
    end else if (clk_en && tck2_ff && !tck3_ff) begin
      last_tms_ff <= tms2_ff;
      ones_ff <= !tms2_ff ? 3'h0 : (ones_ff == `BSTAP_TLR_ONES) ? ones_ff : ones_ff + 3'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_tdo_on_fall: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  a_oe_on_fall: assert property ($changed(tdo_oe_n) |-> !tck)
    else $error("tdo enable moved while tck high");
  a_shift_entry: assert property ($fell(tdo_oe_n) |-> !last_tms_ff)
    else $error("shift entered after tms high");
  a_shift_exit: assert property ($rose(tdo_oe_n) |-> last_tms_ff)
    else $error("shift left after tms low");
  a_five_ones: assert property ((ones_ff == `BSTAP_TLR_ONES) [*4] |->
    pin_out == $past(func_out) && pin_oe_n == $past(func_oe_n))
    else $error("pads not functional after five tms rises");
  a_trst_reset: assert property (!trst_n [*8] |->
    pin_out == $past(func_out) && pin_oe_n == $past(func_oe_n))
    else $error("pads not functional under test reset");
  a_reset_vals: assert property (disable iff (1'b0) rst [*2] |->
    tdo_oe_n && pin_oe_n && pin_out == '0 && core_in == '0)
    else $error("outputs not at reset values");
  a_core_path: assert property ($stable(pin_in) [*4] |-> core_in == pin_in)
    else $error("core input not following pads");
endmodule
bind bstap_top bstap_chk i_chk (.core_clk, .rst, .clk_en, .tck, .tms, .tdi, .trst_n, .tdo,
  .tdo_oe_n, .pin_in, .core_in, .func_out, .func_oe_n, .pin_out, .pin_oe_n);
`default_nettype wire

// ### tb/bstap_ctl.sv
// model of the external test controller driving the port
`timescale 1ns/100ps
`default_nettype none
module bstap_ctl (
  input  wire logic core_clk, // bench clock
  input  wire logic tdo,      // serial out
  input  wire logic tdo_oe_n, // low while tdo driven
  output var logic  tck,      // test clock, still between frames
  output var logic  tms,      // mode select
  output var logic  tdi,      // serial in
  output var logic  trst_n    // test reset
);
  // ----------------------------------------
  // pin driving, four inputs and one output
  // ----------------------------------------
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    trst_n = 1'b1;
  end
  // one 160 ns tck period; tdo read just before the rise
  task automatic step(input logic m, input logic d, output logic q, output logic qo);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge core_clk);
    q = tdo;
    qo = tdo_oe_n;
    tck <= 1'b1;
    repeat (8) @(posedge core_clk);
    tck <= 1'b0;
  endtask
  task automatic pulse_trst();
    trst_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    trst_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### tb/test_boundary_scan_tap_controller.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
`default_nettype none
`include "bstap_map.svh"
module test_boundary_scan_tap_controller;
  localparam logic [3:0]  VER  = 4'h3;    // arbitrary value
  localparam logic [15:0] PART = 16'hc0de; // arbitrary value
  localparam logic [10:0] MAKR = 11'h15a;  // arbitrary value
  logic            core_clk  = 1'b0;
  logic            rst       = 1'b1;
  logic [3:0]      pin_in    = 4'ha;
  logic [3:0]      func_out  = 4'h5;
  logic            func_oe_n = 1'b0;
  logic            q, qo;
  logic [31:0]     d;
  wire logic       tck, tms, tdi, trst_n, tdo, tdo_oe_n, pin_oe_n;
  wire logic [3:0] core_in, pin_out;
  int              n_errors   = 0;
  int              num_checks = 0;
  always #5 core_clk = ~core_clk;
  bstap_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKR)) i_dut (
    .core_clk, .rst, .clk_en(1'b1), .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe_n,
    .pin_in, .core_in, .func_out, .func_oe_n, .pin_out, .pin_oe_n);
  bstap_ctl i_ctl (.core_clk, .tdo, .tdo_oe_n, .tck, .tms, .tdi, .trst_n);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // idle to idle; pz pauses after bit 0 and returns through exit2
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic pz);
    d = '0;
    i_ctl.step(1'b1, 1'b0, q, qo);
    if (ir) i_ctl.step(1'b1, 1'b0, q, qo);
    i_ctl.step(1'b0, 1'b0, q, qo);
    i_ctl.step(1'b0, 1'b0, q, qo);
    chk("tdo enable in capture", 32'(qo), 32'h1);
    for (int i = 0; i < n; i++) begin
      i_ctl.step(i == n - 1 || (pz && i == 0), din[i], q, qo);
      d[i] = q;
      chk("tdo enable in shift", 32'(qo), 32'h0);
      if (pz && i == 0) begin
        i_ctl.step(1'b0, 1'b0, q, qo);
        i_ctl.step(1'b0, 1'b1, q, qo);
        chk("tdo enable in pause", 32'(qo), 32'h1);
        i_ctl.step(1'b1, 1'b0, q, qo);
        i_ctl.step(1'b0, 1'b0, q, qo);
      end
    end
    i_ctl.step(1'b1, 1'b0, q, qo);
    i_ctl.step(1'b0, 1'b0, q, qo);
  endtask
  task automatic t_ident();
    i_ctl.step(1'b0, 1'b0, q, qo);
    scan(1'b0, 32, 32'h0, 1'b1);
    chk("ident", d, {VER, PART, MAKR, 1'b1});
    $display("ident scan done");
  endtask
  task automatic t_bypass();
    scan(1'b1, 4, 32'(`BSTAP_OP_BYPASS), 1'b1);
    chk("ir capture", d, 32'(`BSTAP_IR_CAPTURE));
    scan(1'b0, 8, 32'hb5, 1'b0);
    chk("bypass path", d, 32'h6a);
    $display("bypass done");
  endtask
  task automatic t_boundary();
    scan(1'b1, 4, 32'(`BSTAP_OP_SAMPLE), 1'b0);
    scan(1'b0, 9, 32'h0c3, 1'b1);
    chk("boundary capture", d, 32'h05a);
    chk("pads under sample", {pin_oe_n, pin_out}, 32'h05);
    func_out <= 4'h9;
    func_oe_n <= 1'b1;
    scan(1'b1, 4, 32'(`BSTAP_OP_EXTEST), 1'b0);
    chk("pads under extest", {pin_oe_n, pin_out}, 32'h0c);
    chk("core inputs", 32'(core_in), 32'ha);
    repeat (5) i_ctl.step(1'b1, 1'b0, q, qo);
    chk("pads after tms reset", {pin_oe_n, pin_out}, 32'h19);
    t_ident();
    $display("boundary done");
  endtask
  task automatic t_highz();
    func_oe_n <= 1'b0;
    scan(1'b1, 4, 32'(`BSTAP_OP_HIGHZ), 1'b0);
    chk("pad enable under high-z", 32'(pin_oe_n), 32'h1);
    scan(1'b0, 4, 32'h9, 1'b0);
    chk("high-z bypass path", d, 32'h2);
    i_ctl.pulse_trst();
    repeat (4) @(posedge core_clk);
    chk("pad enable after test reset", 32'(pin_oe_n), 32'h0);
    t_ident();
    $display("high-z done");
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_ident();
    t_bypass();
    t_boundary();
    t_highz();
    finish_test();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
